// ===== verilog/sbsf_consts.svh
// Offsets, field positions, reset values and sizes of the serial buffer block
`ifndef SBSF_CONSTS_SVH
`define SBSF_CONSTS_SVH
`define SBSF_OFF_STAT 4'h0
`define SBSF_OFF_CTRL 4'h1
`define SBSF_OFF_DATA 4'h2
`define SBSF_OFF_IRQ_STAT 4'h3
`define SBSF_OFF_IRQ_MASK 4'h4
`define SBSF_BIT_RBF 0
`define SBSF_BIT_TBF 1
`define SBSF_BIT_BUFFER_IRQ_SELECT_LO 2
`define SBSF_BIT_RXMPT 5
`define SBSF_BIT_ROV 6
`define SBSF_BIT_SHIFT_REG_EMPTY_FLAG 7
`define SBSF_BIT_BEC_LO 8
`define SBSF_BIT_EN 15
`define SBSF_CTRL_ENH 0
`define SBSF_CTRL_MASTER 1
`define SBSF_CTRL_MODE16 2
`define SBSF_STAT_RESET 16'h0000
`define SBSF_CTRL_RESET 16'h0000
`define SBSF_FIFO_DEPTH 8
`define SBSF_FIFO_AW 3
`define SBSF_IRQ_EVT_W 2
`define SBSF_SCK_DIV_LAST 4'hF
`endif

// ===== verilog/sbsf_pkg.sv
// Types of the serial buffer block
`default_nettype none
package sbsf_pkg;
	typedef enum logic [2:0] {
		SBSF_IRQ_LAST_READ = 3'h0,
		SBSF_IRQ_RX_AVAIL = 3'h1,
		SBSF_IRQ_RX_3Q = 3'h2,
		SBSF_IRQ_RX_FULL = 3'h3,
		SBSF_IRQ_TX_DONE = 3'h5
	} sbsf_isel_t;
	typedef enum logic [2:0] {
		SBSF_SH_IDLE = 3'b001,
		SBSF_SH_SHIFT = 3'b010,
		SBSF_SH_DONE = 3'b100
	} sbsf_shift_t;
endpackage
`default_nettype wire

// ===== verilog/sbsf_sync.sv
// Two-stage synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module sbsf_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic meta_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/sbsf_fifo.sv
// Eight-entry word FIFO with registered read data and level count
`timescale 1ns/1ps
`default_nettype none
module sbsf_fifo (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire logic [15:0] wdata,
	input wire logic pop,
	output logic [15:0] rdata,
	output logic [3:0] count
);
	logic [15:0] mem_ff [0:7];
	logic [2:0] wp_ff;
	logic [2:0] rp_ff;
	logic [3:0] cnt_ff;
	wire do_push = push && (cnt_ff != 4'h8);
	wire do_pop = pop && (cnt_ff != 4'h0);
	assign count = cnt_ff;
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_ff[wp_ff] <= wdata;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff <= 3'h0;
			rp_ff <= 3'h0;
			cnt_ff <= 4'h0;
			rdata <= 16'h0000;
		end else if (flush) begin
			wp_ff <= 3'h0;
			rp_ff <= 3'h0;
			cnt_ff <= 4'h0;
		end else begin
			if (do_push) begin
				wp_ff <= wp_ff + 3'h1;
			end
			if (do_pop) begin
				rp_ff <= rp_ff + 3'h1;
				rdata <= mem_ff[rp_ff];
			end
			cnt_ff <= cnt_ff + {3'h0, do_push} - {3'h0, do_pop};
		end
	end
endmodule
`default_nettype wire

// ===== verilog/sbsf_top.sv
// Serial port buffer status flags, data buffers and shift register
`timescale 1ns/1ps
`default_nettype none
`include "sbsf_consts.svh"
module sbsf_top (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic SCK_IN,
	input wire logic SDI_IN,
	output logic SCK_OUT,
	output logic SCK_OE,
	output logic SDO,
	output logic IRQ
);
	import sbsf_pkg::*;

	logic sck_s;
	logic sdi_s;
	sbsf_sync u_sync_sck (.clk(REF_CLK), .rst_n(RESET_N), .din(SCK_IN), .dout(sck_s));
	sbsf_sync u_sync_sdi (.clk(REF_CLK), .rst_n(RESET_N), .din(SDI_IN), .dout(sdi_s));

	// Registers
	logic en_ff;
	logic [2:0] isel_ff;
	logic rov_ff;
	logic enh_ff;
	logic master_ff;
	logic mode16_ff;
	logic [1:0] ist_ff;
	logic [1:0] imask_ff;
	logic [15:0] txb_ff;
	logic txb_full_ff;
	logic [15:0] rxb_ff;
	logic rxb_full_ff;
	logic [15:0] sr_ff;
	logic [4:0] bits_ff;
	logic sck_d_ff;
	logic sck_gen_ff;
	logic [3:0] div_ff;
	logic rd_q_ff;
	logic [15:0] rdata_ff;
	logic data_rd_q_ff;
	sbsf_shift_t st_ff;
	sbsf_shift_t nxt_st;

	// Decode
	wire wr_stat = WR && (ADDR == `SBSF_OFF_STAT);
	wire wr_ctrl = WR && (ADDR == `SBSF_OFF_CTRL);
	wire wr_data = WR && (ADDR == `SBSF_OFF_DATA) && en_ff;
	wire wr_ist = WR && (ADDR == `SBSF_OFF_IRQ_STAT);
	wire wr_imask = WR && (ADDR == `SBSF_OFF_IRQ_MASK);
	wire rd_data = RD && (ADDR == `SBSF_OFF_DATA) && en_ff;

	// Shift engine events
	wire sck_rise = sck_s && !sck_d_ff;
	wire sck_fall = !sck_s && sck_d_ff;
	wire [4:0] nbits = mode16_ff ? 5'h10 : 5'h08;
	wire shifting = (st_ff == SBSF_SH_SHIFT);
	wire word_done = shifting && sck_rise && (bits_ff == nbits - 5'h01);
	// Word including the bit taken on this edge, so the last bit is kept
	wire [15:0] sr_shifted = mode16_ff ? {sr_ff[14:0], sdi_s} : {8'h00, sr_ff[6:0], sdi_s};

	// Transmit source
	logic [3:0] tx_cnt;
	logic [15:0] tx_q;
	wire tx_have = enh_ff ? (tx_cnt != 4'h0) : txb_full_ff;
	wire tx_load = en_ff && (st_ff == SBSF_SH_IDLE) && tx_have;
	wire tx_pop = enh_ff && tx_load;
	// Enhanced mode read data of the FIFO arrive a cycle after pop
	logic tx_pop_q_ff;

	// Receive sink
	logic [3:0] rx_cnt;
	logic [15:0] rx_q;
	wire rx_room = enh_ff ? (rx_cnt != 4'h8) : !rxb_full_ff;
	wire rx_ovf = word_done && (!rx_room || rov_ff);
	wire rx_take = word_done && rx_room && !rov_ff;

	sbsf_fifo u_txf (
		.clk(REF_CLK), .rst_n(RESET_N), .flush(!enh_ff || !en_ff),
		.push(wr_data && enh_ff), .wdata(WDATA), .pop(tx_pop),
		.rdata(tx_q), .count(tx_cnt)
	);
	sbsf_fifo u_rxf (
		.clk(REF_CLK), .rst_n(RESET_N), .flush(!enh_ff || !en_ff),
		.push(rx_take && enh_ff), .wdata(sr_shifted), .pop(rd_data && enh_ff),
		.rdata(rx_q), .count(rx_cnt)
	);

	// Flag views
	// full: holding buffer in standard mode, FIFO at eight entries in enhanced mode
	wire tbf = enh_ff ? (tx_cnt == 4'h8) : txb_full_ff;
	wire rbf = enh_ff ? (rx_cnt == 4'h8) : rxb_full_ff;
	wire rxmpt = enh_ff && (rx_cnt == 4'h0);
	wire shift_reg_empty_flag = enh_ff && !shifting && !tx_pop_q_ff;
	wire [3:0] bec_raw = master_ff ? tx_cnt : rx_cnt;
	wire [2:0] bec = enh_ff ? bec_raw[2:0] : 3'h0;

	wire [15:0] stat_word = {en_ff, 4'h0, bec, shift_reg_empty_flag, rov_ff, rxmpt, isel_ff, tbf, rbf};
	wire [15:0] ctrl_word = {13'h0, mode16_ff, master_ff, enh_ff};

	logic buf_evt;
	always_comb begin
		case (isel_ff)
			SBSF_IRQ_TX_DONE: buf_evt = word_done;
			SBSF_IRQ_RX_FULL: buf_evt = (rx_cnt == 4'h8);
			SBSF_IRQ_RX_3Q: buf_evt = (rx_cnt >= 4'h6);
			SBSF_IRQ_RX_AVAIL: buf_evt = (rx_cnt != 4'h0);
			SBSF_IRQ_LAST_READ: buf_evt = rd_data && (rx_cnt == 4'h1);
			default: buf_evt = 1'b0;
		endcase
	end
	wire [1:0] evt = {rx_ovf, enh_ff ? buf_evt : rx_take};
	assign IRQ = |(ist_ff & imask_ff);

	// Shift state machine
	always_comb begin
		case (st_ff)
			SBSF_SH_IDLE: nxt_st = tx_load ? SBSF_SH_SHIFT : SBSF_SH_IDLE;
			SBSF_SH_SHIFT: nxt_st = word_done ? SBSF_SH_DONE : SBSF_SH_SHIFT;
			SBSF_SH_DONE: nxt_st = SBSF_SH_IDLE;
			default: nxt_st = SBSF_SH_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_ff <= SBSF_SH_IDLE;
			bits_ff <= 5'h00;
			sr_ff <= 16'h0000;
			sck_d_ff <= 1'b0;
			tx_pop_q_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			sck_d_ff <= sck_s;
			tx_pop_q_ff <= tx_pop;
			if (tx_load && !enh_ff) begin
				sr_ff <= txb_ff;
				bits_ff <= 5'h00;
			end else if (tx_pop_q_ff) begin
				sr_ff <= tx_q;
				bits_ff <= 5'h00;
			end else if (shifting && sck_rise) begin
				sr_ff <= sr_shifted;
				bits_ff <= bits_ff + 5'h01;
			end
		end
	end

	// Master clock generator, data out on falling edge
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_ff <= 4'h0;
			sck_gen_ff <= 1'b0;
			SDO <= 1'b0;
		end else begin
			div_ff <= shifting ? div_ff + 4'h1 : 4'h0;
			if (shifting && master_ff && div_ff == `SBSF_SCK_DIV_LAST) begin
				sck_gen_ff <= !sck_gen_ff;
			end else if (!shifting) begin
				sck_gen_ff <= 1'b0;
			end
			if (shifting && (sck_fall || bits_ff == 5'h00)) begin
				SDO <= mode16_ff ? sr_ff[15] : sr_ff[7];
			end
		end
	end
	assign SCK_OUT = sck_gen_ff;
	assign SCK_OE = en_ff && master_ff;

	// Holding buffers and flags
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			txb_ff <= 16'h0000;
			txb_full_ff <= 1'b0;
			rxb_ff <= 16'h0000;
			rxb_full_ff <= 1'b0;
		end else begin
			if (wr_data && !enh_ff) begin
				txb_ff <= WDATA;
				txb_full_ff <= 1'b1;
			end else if (tx_load || enh_ff) begin
				txb_full_ff <= 1'b0;
			end
			if (rx_take && !enh_ff) begin
				rxb_ff <= sr_shifted;
				rxb_full_ff <= 1'b1;
			end else if ((rd_data && !enh_ff) || enh_ff) begin
				rxb_full_ff <= 1'b0;
			end
		end
	end

	// Software registers
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			en_ff <= 1'b0;
			isel_ff <= 3'h0;
			rov_ff <= 1'b0;
			enh_ff <= 1'b0;
			master_ff <= 1'b0;
			mode16_ff <= 1'b0;
			ist_ff <= 2'h0;
			imask_ff <= 2'h0;
		end else begin
			if (wr_stat) begin
				en_ff <= WDATA[`SBSF_BIT_EN];
				isel_ff <= WDATA[`SBSF_BIT_BUFFER_IRQ_SELECT_LO +: 3];
			end
			if (rx_ovf) begin
				rov_ff <= 1'b1;
			end else if (wr_stat && !WDATA[`SBSF_BIT_ROV]) begin
				rov_ff <= 1'b0;
			end
			if (wr_ctrl) begin
				enh_ff <= WDATA[`SBSF_CTRL_ENH];
				master_ff <= WDATA[`SBSF_CTRL_MASTER];
				mode16_ff <= WDATA[`SBSF_CTRL_MODE16];
			end
			ist_ff <= evt | (ist_ff & ~(wr_ist ? WDATA[1:0] : 2'h0));
			if (wr_imask) begin
				imask_ff <= WDATA[1:0];
			end
		end
	end

	// Read port, data one cycle after strobe
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_ff <= 16'h0000;
			data_rd_q_ff <= 1'b0;
		end else begin
			data_rd_q_ff <= rd_data && enh_ff;
			case (ADDR)
				`SBSF_OFF_STAT: rdata_ff <= RD ? stat_word : 16'h0000;
				`SBSF_OFF_CTRL: rdata_ff <= RD ? ctrl_word : 16'h0000;
				`SBSF_OFF_DATA: rdata_ff <= (RD && !enh_ff) ? rxb_ff : 16'h0000;
				`SBSF_OFF_IRQ_STAT: rdata_ff <= RD ? {14'h0, ist_ff} : 16'h0000;
				`SBSF_OFF_IRQ_MASK: rdata_ff <= RD ? {14'h0, imask_ff} : 16'h0000;
				default: rdata_ff <= 16'h0000;
			endcase
		end
	end
	assign RDATA = data_rd_q_ff ? rx_q : rdata_ff;

	// Checks
	// overrun on receive when full or while the overrun flag is set
	chk_ovf_sets_flag: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		rx_ovf |=> rov_ff) else $error("overrun not flagged");
	chk_ovf_sticky_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		rov_ff && !wr_stat |=> rov_ff) else $error("overrun dropped");
	chk_tbf_std_set: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		wr_data && !enh_ff && !wr_ctrl |=> tbf) else $error("tx full not set");
	chk_rbf_std_clr: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		rd_data && !enh_ff && !rx_take |=> !rxb_full_ff) else $error("rx full not cleared");
	chk_rxmpt_level: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		enh_ff && rx_take |=> !rxmpt) else $error("rx empty after push");
	chk_shift_reg_empty_flag_idle: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		tx_load |=> !shift_reg_empty_flag) else $error("shift empty during transfer");
	chk_rbf_std_set: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		rx_take && !enh_ff && !wr_ctrl |=> rxb_full_ff && rxb_ff == sr_ff)
		else $error("rx buffer not loaded");
	chk_tbf_enh_cnt: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		enh_ff && tx_cnt < 4'h8 |-> !tbf) else $error("tx full early");
	chk_tbf_std_clr: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		tx_load && !enh_ff && !wr_data |=> !txb_full_ff) else $error("tx full kept");
endmodule
`default_nettype wire

// ===== tb/sbsf_partner.sv
// Behavioural external serial master driving the link of the buffer block
`timescale 1ns/1ps
`default_nettype none
module sbsf_partner (
	output logic sck,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
	end
	// Most significant bit first; clock idles low between frames
	task automatic frame(input logic [15:0] word, input int nbits, output logic [15:0] got);
		got = 16'h0000;
		for (int i = nbits - 1; i >= 0; i--) begin
			sdi = word[i];
			#62.5;
			sck = 1'b1;
			got = {got[14:0], sdo};
			#62.5;
			sck = 1'b0;
		end
		// Released data line must not keep its last value
		sdi = ~sdi;
	endtask
endmodule
`default_nettype wire

// ===== tb/sbsf_top_test.sv
// Self-checking bench of the serial buffer status flags block
`timescale 1ns/1ps
`default_nettype none
`include "sbsf_consts.svh"
module sbsf_top_test;
	import sbsf_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata, d, got;
	logic sck, sdi, sdo, irq, sck_out, sck_oe;
	logic [15:0] w[9];
	logic [15:0] p[8];
	int err_count = 0;
	int cmp_count = 0;
	integer seed = 32'h1131216d;
	always #5 ref_clk = ~ref_clk;
	sbsf_top u_sbsf_top (.REF_CLK(ref_clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr_s), .RD(rd_s), .RDATA(rdata), .SCK_IN(sck), .SDI_IN(sdi), .SCK_OUT(sck_out),
		.SCK_OE(sck_oe), .SDO(sdo), .IRQ(irq));
	sbsf_partner u_sbsf_partner (.sck(sck), .sdi(sdi), .sdo(sdo));
	function automatic logic [15:0] stat_wr(input logic [2:0] sel);
		stat_wr = 16'h8000 | {11'h000, sel, 2'b00};
	endfunction
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		rd_s <= 1'b0;
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge ref_clk);
	endtask
	task automatic idle();
		wr_s <= 1'b0;
		rd_s <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		wr_s <= 1'b0;
		addr <= a;
		rd_s <= 1'b1;
		@(posedge ref_clk);
		rd_s <= 1'b0;
		// Answer stands in the cycle after the strobe; taken at the closing edge
		@(posedge ref_clk);
		v = rdata;
	endtask
	task automatic sbit(input string name, input int idx, input logic exp);
		rd(`SBSF_OFF_STAT, d);
		chk(name, {15'h0000, exp}, {15'h0000, d[idx]});
	endtask
	task automatic fr(input logic [15:0] v);
		u_sbsf_partner.frame(v, 8, got);
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(`SBSF_OFF_STAT, d);
		chk("stat reset", `SBSF_STAT_RESET, d);
		rd(`SBSF_OFF_CTRL, d);
		chk("ctrl reset", `SBSF_CTRL_RESET, d);
		rd(4'hF, d);
		chk("unmapped", 16'h0000, d);
		wr(`SBSF_OFF_STAT, stat_wr(3'h0));
		wr(`SBSF_OFF_IRQ_MASK, 16'h0002);
		for (int i = 0; i < 4; i++) begin
			w[i] = 16'($random(seed));
			p[i] = 16'($random(seed));
		end
		wr(`SBSF_OFF_DATA, w[0]);
		wr(`SBSF_OFF_DATA, w[1]);
		idle();
		idle();
		sbit("tx full", `SBSF_BIT_TBF, 1'b1);
		fr(p[0]);
		chk("sent word", {8'h00, w[0][7:0]}, got);
		sbit("tx full", `SBSF_BIT_TBF, 1'b0);
		sbit("rx full", `SBSF_BIT_RBF, 1'b1);
		rd(`SBSF_OFF_DATA, d);
		chk("rx data", {8'h00, p[0][7:0]}, {8'h00, d[7:0]});
		sbit("rx full", `SBSF_BIT_RBF, 1'b0);
		fr(p[1]);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		wr(`SBSF_OFF_DATA, w[2]);
		idle();
		fr(p[2]);
		sbit("overrun", `SBSF_BIT_ROV, 1'b1);
		chk("irq overrun", 16'h0001, {15'h0000, irq});
		rd(`SBSF_OFF_DATA, d);
		chk("kept data", {8'h00, p[1][7:0]}, {8'h00, d[7:0]});
		sbit("overrun", `SBSF_BIT_ROV, 1'b1);
		wr(`SBSF_OFF_STAT, stat_wr(3'h0));
		wr(`SBSF_OFF_IRQ_STAT, 16'h0002);
		idle();
		idle();
		sbit("overrun", `SBSF_BIT_ROV, 1'b0);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		// Word mode frame
		wr(`SBSF_OFF_CTRL, 16'h0004);
		wr(`SBSF_OFF_DATA, w[3]);
		idle();
		u_sbsf_partner.frame(p[3], 16, got);
		repeat (6) @(posedge ref_clk);
		chk("sent word16", w[3], got);
		rd(`SBSF_OFF_DATA, d);
		chk("rx word16", p[3], d);
		chk("sck idle", 16'h0000, {15'h0000, sck_oe});
		$display("test standard done");
		wr(`SBSF_OFF_STAT, 16'h0000);
		wr(`SBSF_OFF_CTRL, 16'h0001);
		wr(`SBSF_OFF_STAT, stat_wr(SBSF_IRQ_RX_FULL));
		wr(`SBSF_OFF_IRQ_STAT, 16'h0003);
		wr(`SBSF_OFF_IRQ_MASK, 16'h0001);
		idle();
		sbit("rx empty", `SBSF_BIT_RXMPT, 1'b1);
		sbit("shift empty", `SBSF_BIT_SHIFT_REG_EMPTY_FLAG, 1'b1);
		for (int i = 0; i < 9; i++) begin
			w[i] = 16'($random(seed));
			wr(`SBSF_OFF_DATA, w[i]);
		end
		idle();
		idle();
		sbit("tx full", `SBSF_BIT_TBF, 1'b1);
		for (int i = 0; i < 8; i++) begin
			p[i] = 16'($random(seed));
			fr(p[i]);
			if (i == 0) begin
				chk("sent word", {8'h00, w[0][7:0]}, got);
				sbit("tx full", `SBSF_BIT_TBF, 1'b0);
				sbit("rx empty", `SBSF_BIT_RXMPT, 1'b0);
				chk("count", 16'h0001, {13'h0000, d[10:8]});
			end
			if (i == 6)
				chk("irq not full", 16'h0000, {15'h0000, irq});
		end
		sbit("rx full", `SBSF_BIT_RBF, 1'b1);
		chk("count full", 16'h0000, {13'h0000, d[10:8]});
		chk("irq full", 16'h0001, {15'h0000, irq});
		rd(`SBSF_OFF_DATA, d);
		chk("rx data", {8'h00, p[0][7:0]}, {8'h00, d[7:0]});
		sbit("rx full", `SBSF_BIT_RBF, 1'b0);
		wr(`SBSF_OFF_STAT, stat_wr(SBSF_IRQ_LAST_READ));
		wr(`SBSF_OFF_IRQ_STAT, 16'h0001);
		idle();
		idle();
		chk("irq early", 16'h0000, {15'h0000, irq});
		for (int i = 1; i < 8; i++) begin
			rd(`SBSF_OFF_DATA, d);
			chk("rx data", {8'h00, p[i][7:0]}, {8'h00, d[7:0]});
		end
		idle();
		idle();
		chk("irq last read", 16'h0001, {15'h0000, irq});
		sbit("rx empty", `SBSF_BIT_RXMPT, 1'b1);
		$display("test enhanced done");
		// Master: count shows pending transfers, clock pin driven and running
		wr(`SBSF_OFF_CTRL, 16'h0003);
		wr(`SBSF_OFF_DATA, w[0]);
		wr(`SBSF_OFF_DATA, w[1]);
		idle();
		chk("sck enable", 16'h0001, {15'h0000, sck_oe});
		sbit("shift empty", `SBSF_BIT_SHIFT_REG_EMPTY_FLAG, 1'b0);
		chk("count master", 16'h0002, {13'h0000, d[10:8]});
		d[0] = sck_out;
		repeat (16) @(posedge ref_clk);
		chk("sck toggles", {15'h0000, ~d[0]}, {15'h0000, sck_out});
		$display("test master done");
		summarize();
	end
endmodule
`default_nettype wire
